/* File: hw/hfi_params.svh */
`ifndef HFI_PARAMS_SVH
`define HFI_PARAMS_SVH

// register word addresses on the host register port
`define HFI_ADDR_PENDING 16'h0006
`define HFI_ADDR_LOGPTR 16'h000A
`define HFI_ADDR_ENABLE 16'h000F
`define HFI_ADDR_OUTEN 16'h0013
`define HFI_LOG_BASE 16'h0180
`define HFI_LOG_LAST 16'h01BF

// field positions shared by pending, enable and output enable
`define HFI_BIT_EEPROM 14
`define HFI_BIT_INIT 13

// reset values of the two enable bits (bit 14, bit 13)
`define HFI_EN_RESET 2'h3
`define HFI_LOGPTR_BASE 3'h6

// timing: clock period and transmitter watchdog limit
`define HFI_CLK_NS 25
`define HFI_WDOG_NS 663000
`define HFI_WDOG_CYCLES (`HFI_WDOG_NS / `HFI_CLK_NS)

`endif

/* File: hw/hfi_pkg.sv */
package hfi_pkg;

   // fault events from the loader, ram checker and init compare
   typedef struct packed {
      logic eepromChecksumError;
      logic ramInitMismatch;
      logic ramParityFail;
      logic [12:0] parityAddr;
   } hfi_fault_t;

   // host register request as decoded by the serial host port
   typedef struct packed {
      logic rd;
      logic wr;
      logic [15:0] addr;
      logic [15:0] data;
   } hfi_reg_req_t;

   // log writer states, gray along the path
   typedef enum logic [1:0] {
      HFI_LOG_IDLE = 2'b00,
      HFI_LOG_WR_ID = 2'b01,
      HFI_LOG_WR_IAW = 2'b11
   } hfi_log_state_t;

endpackage

/* File: hw/hfi_log_mem.sv */
`timescale 1ns/1ps
`default_nettype none

// small synchronous ram holding the interrupt log, registered read data
module hfi_log_mem #(
   parameter int WIDTH = 16,
   parameter int DEPTH = 64,
   parameter int AW = 6
) (
   input wire logic clk_sys,
   input wire logic wrEn,
   input wire logic [AW-1:0] wrAddr,
   input wire logic [WIDTH-1:0] wrData,
   input wire logic rdEn,
   input wire logic [AW-1:0] rdAddr,
   output logic [WIDTH-1:0] rdData
);

   logic [WIDTH-1:0] mem [DEPTH];

   // write port
   always_ff @(posedge clk_sys) begin
      if (wrEn) begin
         mem[wrAddr] <= wrData;
      end
   end

   // read port, data held until next read
   always_ff @(posedge clk_sys) begin
      if (rdEn) begin
         rdData <= mem[rdAddr];
      end
   end

endmodule

`default_nettype wire

/* File: hw/hfi_fault_irq.sv */
`timescale 1ns/1ps
`default_nettype none
`include "hfi_params.svh"

// Function
// - checksum and init faults reported only if auto-init select high at reset release.
// - after reset, enable and output enable bits 14 and 13 read one.
// - eeprom checksum error sets pending bit 14 and master status bit 1.
// - ram parity failure sets pending bit 14.
// - parity errors are reported only, never corrected.
// - master status bit 1 is one for checksum error, zero for parity fail.
// - ram init mismatch sets pending bit 13 and master status bit 0.
// - each transmitter has a watchdog limiting transmission to 663 us.
// - enabled watchdog expiry sets pending bit and writes a log entry.
// - watchdog raises interrupt pin only when output enable bit 13 set.
// - enabled interrupts write two-word entries into a circular 64-word log; events in one cycle or during one busy write share one entry.
// - second log word is zero, or the failing address for parity fail.
module hfi_fault_irq #(
   parameter int WDOG_CYCLES = `HFI_WDOG_CYCLES,
   parameter int WD_W = 15
) (
   input wire logic clk_sys,
   input wire logic rstn,
   input wire logic autoInitSelect,
   input wire logic terminalSoftReset,
   input wire hfi_pkg::hfi_fault_t fault,
   input wire logic [1:0] txActive,
   output logic [1:0] txInhibit,
   input wire hfi_pkg::hfi_reg_req_t regReq,
   output logic [15:0] regRdData,
   output logic regRdValid,
   output logic [1:0] masterStatus,
   output logic irqN
);
   localparam logic [WD_W-1:0] WD_LAST = WD_W'(WDOG_CYCLES - 1);

   // -------------------------------------------------
   // auto-init strap
   // -------------------------------------------------
   logic autoSync1, autoSync2, strapTaken, auto_init_select;

   // two-stage synchroniser on the strap pin
   always_ff @(posedge clk_sys) begin
      autoSync1 <= autoInitSelect;
      autoSync2 <= autoSync1;
   end

   always_ff @(posedge clk_sys) begin
      if (!rstn) begin
         strapTaken <= 1'b0;
         auto_init_select <= 1'b0;
      end else if (!strapTaken) begin
         strapTaken <= 1'b1;
         auto_init_select <= autoSync2;
      end
   end

   // -------------------------------------------------
   // transmitter watchdogs
   // -------------------------------------------------
   logic [WD_W-1:0] wdCnt [2];
   logic [1:0] wdFire;

   generate
      for (genvar g = 0; g < 2; g++) begin : g_wdog
         assign wdFire[g] = txActive[g] && !txInhibit[g] && (wdCnt[g] == WD_LAST);
         always_ff @(posedge clk_sys) begin
            if (!rstn || !txActive[g]) begin
               wdCnt[g] <= '0;
               txInhibit[g] <= 1'b0;
            end else if (wdFire[g]) begin
               txInhibit[g] <= 1'b1;
            end else if (!txInhibit[g]) begin
               wdCnt[g] <= wdCnt[g] + WD_W'(1);
            end
         end
      end
   endgenerate

   // -------------------------------------------------
   // register decode
   // -------------------------------------------------
   function automatic logic hfiHit(input logic [15:0] a, input logic [15:0] ref_a);
      hfiHit = (a == ref_a);
   endfunction

   wire rdPend = regReq.rd && hfiHit(regReq.addr, `HFI_ADDR_PENDING);
   wire rdPtr = regReq.rd && hfiHit(regReq.addr, `HFI_ADDR_LOGPTR);
   wire rdEn = regReq.rd && hfiHit(regReq.addr, `HFI_ADDR_ENABLE);
   wire rdOut = regReq.rd && hfiHit(regReq.addr, `HFI_ADDR_OUTEN);
   wire wrEnReg = regReq.wr && hfiHit(regReq.addr, `HFI_ADDR_ENABLE);
   wire wrOutReg = regReq.wr && hfiHit(regReq.addr, `HFI_ADDR_OUTEN);
   wire rdLog = regReq.rd && (regReq.addr >= `HFI_LOG_BASE) && (regReq.addr <= `HFI_LOG_LAST);

   // -------------------------------------------------
   // enable, output enable, pending, master status
   // -------------------------------------------------
   logic [1:0] irqEnable, outEnable, pending;
   logic msEe, msInit;

   wire evtEe = fault.eepromChecksumError && auto_init_select;
   wire evtInit = fault.ramInitMismatch && auto_init_select;
   wire evtPar = fault.ramParityFail;
   wire evtWd = |wdFire;

   // parity and checksum share bit 14
   wire set14 = (evtEe || evtPar) && irqEnable[1];
   // watchdog gated by enable bit 13
   wire set13 = (evtInit || evtWd) && irqEnable[0];
   wire [1:0] pendSet = {set14, set13};
   // read clears pending; a set in the same cycle wins
   wire [1:0] next_pending = (pending & ~{2{rdPend}}) | pendSet;

   always_ff @(posedge clk_sys) begin
      if (!rstn) begin
         irqEnable <= `HFI_EN_RESET;
         outEnable <= `HFI_EN_RESET;
      end else begin
         if (wrEnReg) irqEnable <= {regReq.data[`HFI_BIT_EEPROM], regReq.data[`HFI_BIT_INIT]};
         if (wrOutReg) outEnable <= {regReq.data[`HFI_BIT_EEPROM], regReq.data[`HFI_BIT_INIT]};
      end
   end

   // status bit 1 tells checksum from parity
   always_ff @(posedge clk_sys) begin
      if (!rstn) begin
         pending <= 2'h0;
         msEe <= 1'b0;
         msInit <= 1'b0;
      end else begin
         pending <= next_pending;
         if (evtEe) msEe <= 1'b1;
         else if (evtPar || terminalSoftReset) msEe <= 1'b0;
         if (evtInit) msInit <= 1'b1;
         else if (terminalSoftReset) msInit <= 1'b0;
      end
   end

   assign masterStatus = {msEe, msInit};

   // interrupt pin from enabled pending bits
   // watchdog pin gated by output enable 13
   always_ff @(posedge clk_sys) begin
      if (!rstn) irqN <= 1'b1;
      else irqN <= ~|(pending & outEnable);
   end

   // -------------------------------------------------
   // interrupt log writer
   // -------------------------------------------------
   hfi_pkg::hfi_log_state_t logState;
   logic [1:0] accId, curId;
   logic accPar;
   logic [12:0] accAddr;
   logic [15:0] curIaw;
   logic [4:0] pairIdx;
   logic [6:0] logCount;

   wire take = (logState == hfi_pkg::HFI_LOG_IDLE) && (|accId);
   wire parLogged = evtPar && irqEnable[1];

   // collect events while the writer is busy
   always_ff @(posedge clk_sys) begin
      if (!rstn) begin
         accId <= 2'h0;
         accPar <= 1'b0;
         accAddr <= 13'h0000;
      end else begin
         accId <= (take ? 2'h0 : accId) | pendSet;
         accPar <= (take ? 1'b0 : accPar) | parLogged;
         if (parLogged) accAddr <= fault.parityAddr;
      end
   end

   // two words per log entry, circular pointer
   always_ff @(posedge clk_sys) begin
      if (!rstn) begin
         logState <= hfi_pkg::HFI_LOG_IDLE;
         curId <= 2'h0;
         curIaw <= 16'h0000;
         pairIdx <= 5'h00;
         logCount <= 7'h00;
      end else begin
         unique case (logState)
            hfi_pkg::HFI_LOG_IDLE: begin
               if (take) begin
                  curId <= accId;
                  curIaw <= accPar ? {3'h0, accAddr} : 16'h0000;
                  logState <= hfi_pkg::HFI_LOG_WR_ID;
               end
            end
            hfi_pkg::HFI_LOG_WR_ID: logState <= hfi_pkg::HFI_LOG_WR_IAW;
            hfi_pkg::HFI_LOG_WR_IAW: begin
               logState <= hfi_pkg::HFI_LOG_IDLE;
               pairIdx <= pairIdx + 5'h01;
            end
         endcase
         if (rdPtr) logCount <= (logState == hfi_pkg::HFI_LOG_WR_IAW) ? 7'h01 : 7'h00;
         else if (logState == hfi_pkg::HFI_LOG_WR_IAW && logCount != 7'h7F)
            logCount <= logCount + 7'h01;
      end
   end

   wire memWr = (logState != hfi_pkg::HFI_LOG_IDLE);
   wire isIaw = (logState == hfi_pkg::HFI_LOG_WR_IAW);
   wire [5:0] memWrAddr = {pairIdx, isIaw};
   wire [15:0] idWord = {1'b0, curId, 13'h0000};
   wire [15:0] memWrData = isIaw ? curIaw : idWord;
   wire [15:0] logPtrWord = {logCount, `HFI_LOGPTR_BASE, pairIdx, 1'b0};
   logic [15:0] memQ;

   hfi_log_mem #(.WIDTH(16), .DEPTH(64), .AW(6)) u_log (
      .clk_sys(clk_sys),
      .wrEn(memWr),
      .wrAddr(memWrAddr),
      .wrData(memWrData),
      .rdEn(rdLog),
      .rdAddr(regReq.addr[5:0]),
      .rdData(memQ)
   );

   // -------------------------------------------------
   // register read path
   // -------------------------------------------------
   logic [15:0] regQ;
   logic memSel;

   wire [15:0] next_regQ = rdPend ? {1'b0, pending, 13'h0000} :
                           rdEn ? {1'b0, irqEnable, 13'h0000} :
                           rdOut ? {1'b0, outEnable, 13'h0000} :
                           rdPtr ? logPtrWord : 16'h0000;

   // one cycle read latency, unmapped reads give zero
   always_ff @(posedge clk_sys) begin
      if (!rstn) begin
         regQ <= 16'h0000;
         memSel <= 1'b0;
         regRdValid <= 1'b0;
      end else begin
         regQ <= next_regQ;
         memSel <= rdLog;
         regRdValid <= regReq.rd;
      end
   end

   assign regRdData = memSel ? memQ : regQ;

   // -------------------------------------------------
   // checks
   // -------------------------------------------------
   AST_STRAP_GATE: assert property (@(posedge clk_sys) disable iff (!rstn)
      (strapTaken && !auto_init_select && !terminalSoftReset) |=> !$rose(msInit))
      else $error("init status rose without auto-init strap");
   AST_EN_RESET: assert property (@(posedge clk_sys)
      !rstn |=> (irqEnable == 2'h3) && (outEnable == 2'h3))
      else $error("enable bits not one after reset");
   AST_EE_SET: assert property (@(posedge clk_sys) disable iff (!rstn)
      (evtEe && irqEnable[1]) |=> pending[1] && masterStatus[1])
      else $error("checksum error not flagged");
   AST_PAR_SET: assert property (@(posedge clk_sys) disable iff (!rstn)
      (fault.ramParityFail && irqEnable[1]) |=> pending[1] ##[1:3] memWr)
      else $error("parity fail not flagged and logged");
   AST_MS_PAR: assert property (@(posedge clk_sys) disable iff (!rstn)
      (evtPar && !evtEe) |=> !masterStatus[1])
      else $error("status bit 1 set for parity fail");
   AST_INIT_SET: assert property (@(posedge clk_sys) disable iff (!rstn)
      (evtInit && irqEnable[0]) |=> pending[0] && masterStatus[0])
      else $error("init mismatch not flagged");
   AST_WDOG: assert property (@(posedge clk_sys) disable iff (!rstn)
      (txActive[0] && !txInhibit[0] && wdCnt[0] == WD_LAST) |=> txInhibit[0] || !txActive[0])
      else $error("watchdog did not stop transmitter");
   AST_WD_PEND: assert property (@(posedge clk_sys) disable iff (!rstn)
      (evtWd && irqEnable[0]) |=> pending[0])
      else $error("watchdog expiry not pending");
   AST_WD_PIN: assert property (@(posedge clk_sys) disable iff (!rstn)
      (pending == 2'h1 && !outEnable[0]) |=> irqN)
      else $error("pin raised for disabled watchdog output");
   AST_LOG_SEQ: assert property (@(posedge clk_sys) disable iff (!rstn)
      (logState == hfi_pkg::HFI_LOG_WR_ID) |=> (logState == hfi_pkg::HFI_LOG_WR_IAW) ##1
      (logState == hfi_pkg::HFI_LOG_IDLE && pairIdx == $past(pairIdx, 2) + 5'h01))
      else $error("log entry not two words");
   AST_IAW: assert property (@(posedge clk_sys) disable iff (!rstn)
      (take && !accPar) |=> ##1 (memWr && memWrData == 16'h0000))
      else $error("address word not zero");
   AST_IRQ: assert property (@(posedge clk_sys) disable iff (!rstn)
      (|(pending & outEnable)) |=> !irqN)
      else $error("interrupt pin not asserted");

endmodule

`default_nettype wire

/* File: testbench/hfi_host.sv */
`timescale 1ns/1ps
`default_nettype none

// host side model: one register request at a time, strobes held one edge
module hfi_host (
   input wire logic clk_sys,
   output var hfi_pkg::hfi_reg_req_t regReq,
   input wire logic [15:0] regRdData,
   input wire logic regRdValid,
   input wire logic [1:0] masterStatus
);
   // idle bus shows inverted values so a stale request never matches
   initial regReq = '{rd: 1'b0, wr: 1'b0, addr: 16'hffff, data: 16'hffff};

   // drive one request just after an edge, release after the taking edge
   task automatic issue(input logic r, input logic [15:0] a, input logic [15:0] d);
      @(posedge clk_sys);
      regReq <= '{rd: r, wr: !r, addr: a, data: d};
      @(posedge clk_sys);
      regReq <= '{rd: 1'b0, wr: 1'b0, addr: ~a, data: ~d};
   endtask

   task automatic wr(input logic [15:0] a, input logic [15:0] d);
      issue(1'b0, a, d);
   endtask

   // read with a bounded wait for the answer
   task automatic rd(input logic [15:0] a, output logic [15:0] d, output logic ok);
      int i;
      issue(1'b1, a, 16'h0000);
      ok = 1'b0;
      d = 16'h0000;
      for (i = 0; i < 4 && !ok; i++) begin
         #1;
         ok = (regRdValid === 1'b1);
         d = regRdData;
         if (!ok) @(posedge clk_sys);
      end
   endtask

   // source check
   // bit-14 event: one means checksum error, zero means parity fail
   function automatic logic eeprom_source();
      return masterStatus[1];
   endfunction
endmodule

`default_nettype wire

/* File: testbench/hw_fault_interrupt_sources_tb_top.sv */
`timescale 1ns/1ps
`default_nettype none
`define CHK(got, exp) begin checks_done++; if ((got) !== (exp)) begin n_mismatch++; \
   $display("[ERR] t=%0t got=%h exp=%h", $time, (got), (exp)); end end

module hw_fault_interrupt_sources_tb_top;
   localparam int WD = 20;
   typedef struct packed {
      hfi_pkg::hfi_fault_t f;
      logic [1:0] tx;
      logic [15:0] pend;
      logic [1:0] ms;
   } hfi_row_t;

   logic clk_sys = 1'b0;
   logic rstn = 1'b0;
   logic autoInitSelect = 1'b1;
   logic terminalSoftReset = 1'b0;
   hfi_pkg::hfi_fault_t fault = '0;
   logic [1:0] txActive = 2'h0;
   logic [1:0] txInhibit;
   hfi_pkg::hfi_reg_req_t regReq;
   logic [15:0] regRdData;
   logic regRdValid;
   logic [1:0] masterStatus;
   logic irqN;
   int n_mismatch = 0;
   int checks_done = 0;
   int nLog = 0;
   logic [15:0] la;
   // ordinary cases: fault, transmitter, pending word, master status
   hfi_row_t rows [5] = '{
      '{'{1'b1, 1'b0, 1'b0, 13'h0000}, 2'h0, 16'h4000, 2'h2},
      '{'{1'b0, 1'b1, 1'b0, 13'h0000}, 2'h0, 16'h2000, 2'h1},
      '{'{1'b0, 1'b0, 1'b1, 13'h1abc}, 2'h0, 16'h4000, 2'h0},
      '{'{1'b0, 1'b0, 1'b0, 13'h0000}, 2'h1, 16'h2000, 2'h0},
      '{'{1'b0, 1'b0, 1'b0, 13'h0000}, 2'h2, 16'h2000, 2'h0}};

   // 40 MHz clock
   always #12.5 clk_sys = ~clk_sys;

   hfi_fault_irq #(.WDOG_CYCLES(WD), .WD_W(15)) i_hfi_fault_irq (
      .clk_sys(clk_sys), .rstn(rstn), .autoInitSelect(autoInitSelect),
      .terminalSoftReset(terminalSoftReset), .fault(fault), .txActive(txActive),
      .txInhibit(txInhibit), .regReq(regReq), .regRdData(regRdData),
      .regRdValid(regRdValid), .masterStatus(masterStatus), .irqN(irqN));

   hfi_host i_hfi_host (
      .clk_sys(clk_sys), .regReq(regReq), .regRdData(regRdData),
      .regRdValid(regRdValid), .masterStatus(masterStatus));

   // ----------------------------------------
   // helper tasks
   // ----------------------------------------
   task automatic print_verdict();
      $display("checks %0d mismatches %0d", checks_done, n_mismatch);
      if (n_mismatch == 0 && checks_done > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask

   task automatic give_up(input logic hit);
      if (hit) begin
         n_mismatch++;
         print_verdict();
      end
   endtask

   task automatic cyc(input int n);
      repeat (n) @(posedge clk_sys);
   endtask

   task automatic rd_chk(input logic [15:0] a, input logic [15:0] exp);
      logic [15:0] d;
      logic ok;
      i_hfi_host.rd(a, d, ok);
      give_up(!ok);
      `CHK(d, exp)
   endtask

   task automatic fire(input hfi_pkg::hfi_fault_t f);
      @(posedge clk_sys);
      fault <= f;
      @(posedge clk_sys);
      fault <= '0;
   endtask

   task automatic wait_irq(input logic lvl);
      int i;
      for (i = 0; i < 8 && irqN !== lvl; i++) @(posedge clk_sys);
      give_up(i == 8);
   endtask

   // hold a transmitter on until the watchdog stops it
   task automatic run_tx(input logic [1:0] b);
      int n;
      @(posedge clk_sys);
      txActive <= b;
      for (n = 0; n < 3 * WD && txInhibit !== b; n++) @(posedge clk_sys);
      give_up(n == 3 * WD);
      `CHK((n >= WD) && (n <= WD + 3), 1'b1)
      @(posedge clk_sys);
      txActive <= 2'h0;
      cyc(3);
      `CHK(txInhibit, 2'h0)
   endtask

   // ----------------------------------------
   // main sequence
   // ----------------------------------------
   initial begin
      cyc(10);
      rstn <= 1'b1;
      cyc(4);
      foreach (rows[k]) begin
         @(posedge clk_sys);
         terminalSoftReset <= 1'b1;
         @(posedge clk_sys);
         terminalSoftReset <= 1'b0;
         if (rows[k].tx != 2'h0) run_tx(rows[k].tx);
         else fire(rows[k].f);
         wait_irq(1'b0);
         `CHK(masterStatus, rows[k].ms)
         `CHK(i_hfi_host.eeprom_source(), rows[k].ms[1])
         rd_chk(16'h0006, rows[k].pend);
         cyc(3);
         `CHK(irqN, 1'b1)
         la = 16'h0180 + 16'(2 * (nLog % 32));
         rd_chk(la, rows[k].pend);
         rd_chk(la + 16'h0001, {3'h0, rows[k].f.parityAddr});
         nLog++;
         $display("row %0d done", k);
      end
      // log wraps after 32 entries, 33rd lands at the base
      for (int k = nLog; k < 33; k++) begin
         fire('{1'b0, 1'b0, 1'b1, 13'(k)});
         cyc(6);
      end
      rd_chk(16'h0181, 16'h0020);
      rd_chk(16'h000a, {7'h21, 9'h182});
      rd_chk(16'h0006, 16'h4000);
      $display("wrap test done");
      // watchdog with output enable off: pending and log, no pin
      i_hfi_host.wr(16'h0013, 16'h4000);
      run_tx(2'h1);
      cyc(4);
      `CHK(irqN, 1'b1)
      rd_chk(16'h0006, 16'h2000);
      // watchdog with enable off: nothing pends, nothing logged
      i_hfi_host.wr(16'h000f, 16'h4000);
      run_tx(2'h2);
      rd_chk(16'h0006, 16'h0000);
      rd_chk(16'h000a, {7'h01, 9'h184});
      $display("enable test done");
      // second reset with strap low
      @(posedge clk_sys);
      rstn <= 1'b0;
      autoInitSelect <= 1'b0;
      cyc(10);
      rstn <= 1'b1;
      cyc(4);
      rd_chk(16'h000f, 16'h6000);
      rd_chk(16'h0013, 16'h6000);
      rd_chk(16'h000a, 16'h0180);
      rd_chk(16'h0007, 16'h0000);
      fire('{1'b1, 1'b1, 1'b0, 13'h0000});
      cyc(4);
      `CHK(masterStatus, 2'h0)
      `CHK(irqN, 1'b1)
      rd_chk(16'h0006, 16'h0000);
      fire('{1'b0, 1'b0, 1'b1, 13'h0005});
      wait_irq(1'b0);
      rd_chk(16'h0006, 16'h4000);
      rd_chk(16'h0181, 16'h0005);
      $display("reset test done");
      print_verdict();
   end
endmodule

`default_nettype wire
